// File: pkg/rtc_pkg.sv
// Purpose: Shared constants, register map layout and state types of the serial alarm RTC.
// Assumes: Clock of 125 MHz; crystal tick input of 32.768 kHz.
// Notes: Register indices are byte addresses of the serial map (read form, bit 7 clear).
package rtc_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int XTAL_TICKS_PER_SEC = 32768;
    localparam int ALARM1_PULSE_NS = 62_500_000;
    // A longest time rounds down, which integer division already does.
    localparam int ALARM1_PULSE_CYCLES = ALARM1_PULSE_NS / CLK_PERIOD_NS;
    localparam int PRESCALE_W = 16;
    localparam int PULSE_W = 23;
    localparam int REG_COUNT = 17;
    localparam int RAM_BYTES = 96;
    localparam int ALARM_COUNT = 2;
    localparam int ALARM_FIELDS = 4;

    localparam logic [6:0] REG_SEC = 7'h00;
    localparam logic [6:0] REG_MIN = 7'h01;
    localparam logic [6:0] REG_HOUR = 7'h02;
    localparam logic [6:0] REG_DAY = 7'h03;
    localparam logic [6:0] REG_DATE = 7'h04;
    localparam logic [6:0] REG_MONTH = 7'h05;
    localparam logic [6:0] REG_YEAR = 7'h06;
    localparam logic [6:0] REG_ALARM0 = 7'h07;
    localparam logic [6:0] REG_CONTROL = 7'h0F;
    localparam logic [6:0] REG_STATUS = 7'h10;
    localparam logic [6:0] RAM_BASE = 7'h20;

    localparam int HOUR_MODE_12_BIT = 6;
    localparam int HOUR_PM_BIT = 5;
    localparam int ALARM_MASK_BIT = 7;
    localparam int ADDR_WRITE_BIT = 7;
    localparam int CTRL_ALARM0_EN_BIT = 0;
    localparam int CTRL_ALARM1_EN_BIT = 1;
    localparam int CTRL_SECOND_PULSE_EN_BIT = 2;
    localparam int STAT_ALARM0_BIT = 0;

    localparam logic [7:0] BCD_ZERO = 8'h00;
    localparam logic [7:0] BCD_ONE = 8'h01;
    localparam logic [7:0] SEC_MAX = 8'h59;
    localparam logic [7:0] HOUR24_MAX = 8'h23;
    localparam logic [7:0] HOUR12_MAX = 8'h12;
    localparam logic [4:0] HOUR12_ELEVEN = 5'h11;
    localparam logic [7:0] DAY_MAX = 8'h07;
    localparam logic [7:0] MONTH_MAX = 8'h12;
    localparam logic [7:0] YEAR_MAX = 8'h99;
    localparam logic [7:0] MONTH_FEB = 8'h02;
    localparam logic [7:0] MONTH_APR = 8'h04;
    localparam logic [7:0] MONTH_JUN = 8'h06;
    localparam logic [7:0] MONTH_SEP = 8'h09;
    localparam logic [7:0] MONTH_NOV = 8'h11;
    localparam logic [7:0] DAYS_28 = 8'h28;
    localparam logic [7:0] DAYS_29 = 8'h29;
    localparam logic [7:0] DAYS_30 = 8'h30;
    localparam logic [7:0] DAYS_31 = 8'h31;

    typedef logic [0:REG_COUNT-1][7:0] regmap_t;
    // Time 00:00:00, day 1, 01/01/00; alarms, control and status clear.
    localparam regmap_t REGS_RESET = {8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, {10{8'h00}}};

    typedef enum logic [1:0] {
        PH_ADDR = 2'b00,
        PH_WRITE = 2'b01,
        PH_READ = 2'b10
    } phase_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] data;
    } wr_msg_t;

    typedef struct packed {
        logic xtal_s1, xtal_s2, xtal_s3, xclk_out;
        logic ce_s1, ce_s2;
        logic wt_s1, wt_s2, wt_s3;
        logic [PRESCALE_W-1:0] prescale;
        logic tick_d;
        regmap_t regs;
        regmap_t snap;
        logic [PULSE_W-1:0] pulse_cnt;
        logic pulse, spo_oe, irq0_oe;
    } core_state_t;

    typedef struct packed {
        phase_t phase;
        logic [2:0] bitcnt;
        logic [6:0] addr;
        logic [7:0] rx;
    } link_state_t;

    typedef struct packed {
        logic toggle;
        wr_msg_t msg;
        logic strap_s1, strap_s2;
    } xfer_state_t;

    typedef struct packed {
        logic [7:0] shift;
        logic active;
    } tx_state_t;
endpackage

// File: core/serial_alarm_rtc.sv
// Purpose: Serial alarm real-time clock: BCD calendar, two alarms, clock outputs, user RAM, serial port.
// Assumes: Serial port runs on serial_clock; calendar runs on clk; pins feed two-flop synchronisers.
// Notes: Register bytes are snapshot while chip select is low and held while it is high; RAM lives in the serial clock domain.
// Contract
// - Second pulse square wave drives only while its enable bit is one.
// - Strap low selects 3-wire protocol, strap high selects SPI.
// - Every serial bit is timed by edges of the host-driven serial clock.
// - SPI mode samples data on data input, shifts read data out on output.
// - 3-wire mode shares one data line; device drives only during read bits.
// - Crystal clock output runs continuously without any enable.
// - Alarm 0 interrupt and second pulse are open drain, pulling low only.
// - Timekeeping, second pulse and interrupts keep running independent of supply level.
// - Seconds through year are BCD counters chained as a calendar.
// - Date rolls at true month end, including leap February.
// - Hours support 24-hour or 12-hour with AM/PM format.
// - Ninety-six bytes of user storage readable and writable serially.
// - Two independent alarms match seconds, minutes, hours and day.
// - Each alarm field may be masked out of the comparison.
// - Single-byte or burst transfers within one chip select period.
// - Hours bit 6 high selects 12-hour; bit 5 then means PM.
// - Each update compares both alarms and sets matching status flags.
// - Alarm 0 interrupt stays low while flag and enable are both set.
// - Alarm 1 condition emits one 62.5 ms high pulse.
`timescale 1ns/100ps
module serial_alarm_rtc
    import rtc_pkg::*;
#(
    parameter int ALARM1_PULSE_LEN = ALARM1_PULSE_CYCLES,
    parameter int TICKS_PER_SEC = XTAL_TICKS_PER_SEC
) (
    input logic clk,
    input logic resetn,
    input logic xtal_in,
    output logic crystal_clock_out,
    output logic second_pulse_out,
    output logic second_pulse_oe,
    output logic alarm0_irq_n,
    output logic alarm0_irq_oe,
    output logic alarm1_irq_pulse,
    input logic interface_select_strap,
    input logic chip_select,
    input logic serial_clock,
    input logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe
);
    core_state_t r, n;
    link_state_t link, link_n;
    xfer_state_t xfer, xfer_n;
    tx_state_t tx, tx_n;
    logic [7:0] ram [0:RAM_BYTES-1];
    logic [ALARM_COUNT-1:0] alarm_hit;
    logic tick, wr_apply, wr_fire, link_rstn, lsb_first;
    logic [7:0] rx_byte, rd_byte;

    function automatic logic [8:0] bcd_step(logic [7:0] v, logic [7:0] max, logic [7:0] min);
        if (v == max) begin
            return {1'b1, min};
        end
        if (v[3:0] == 4'h9) begin
            return {1'b0, v[7:4] + 4'h1, 4'h0};
        end
        return {1'b0, v[7:4], v[3:0] + 4'h1};
    endfunction

    function automatic logic [7:0] last_day(logic [7:0] month, logic [7:0] year);
        logic leap;
        leap = year[4] ? (year[3:0] == 4'h2 || year[3:0] == 4'h6)
                       : (year[3:0] == 4'h0 || year[3:0] == 4'h4 || year[3:0] == 4'h8);
        if (month == MONTH_FEB) begin
            return leap ? DAYS_29 : DAYS_28;
        end
        if (month == MONTH_APR || month == MONTH_JUN || month == MONTH_SEP || month == MONTH_NOV) begin
            return DAYS_30;
        end
        return DAYS_31;
    endfunction

    // One second of calendar advance; the carry ripples from seconds up to the year.
    function automatic regmap_t advance(regmap_t m);
        logic [8:0] t;
        logic c;
        logic [7:0] h;
        t = bcd_step(m[REG_SEC], SEC_MAX, BCD_ZERO);
        m[REG_SEC] = t[7:0];
        c = t[8];
        if (c) begin
            t = bcd_step(m[REG_MIN], SEC_MAX, BCD_ZERO);
            m[REG_MIN] = t[7:0];
            c = t[8];
        end
        if (c) begin
            h = m[REG_HOUR];
            if (h[HOUR_MODE_12_BIT]) begin
                t = bcd_step({3'h0, h[4:0]}, HOUR12_MAX, BCD_ONE);
                c = (h[4:0] == HOUR12_ELEVEN) && h[HOUR_PM_BIT];
                h[HOUR_PM_BIT] = h[HOUR_PM_BIT] ^ (h[4:0] == HOUR12_ELEVEN);
                h[4:0] = t[4:0];
            end else begin
                t = bcd_step({2'h0, h[5:0]}, HOUR24_MAX, BCD_ZERO);
                h = t[7:0];
                c = t[8];
            end
            m[REG_HOUR] = h;
        end
        if (c) begin
            t = bcd_step(m[REG_DAY], DAY_MAX, BCD_ONE);
            m[REG_DAY] = t[7:0];
            t = bcd_step(m[REG_DATE], last_day(m[REG_MONTH], m[REG_YEAR]), BCD_ONE);
            m[REG_DATE] = t[7:0];
            c = t[8];
        end
        if (c) begin
            t = bcd_step(m[REG_MONTH], MONTH_MAX, BCD_ONE);
            m[REG_MONTH] = t[7:0];
            c = t[8];
        end
        if (c) begin
            t = bcd_step(m[REG_YEAR], YEAR_MAX, BCD_ZERO);
            m[REG_YEAR] = t[7:0];
        end
        return m;
    endfunction

    function automatic logic alarm_match(regmap_t m, logic [6:0] base);
        logic hit;
        hit = 1'b1;
        for (int k = 0; k < ALARM_FIELDS; k++) begin
            if (!m[base + k][ALARM_MASK_BIT] && m[base + k][6:0] != m[k][6:0]) begin
                hit = 1'b0;
            end
        end
        return hit;
    endfunction

    for (genvar g = 0; g < ALARM_COUNT; g++) begin : g_alarm
        assign alarm_hit[g] = alarm_match(r.regs, 7'(REG_ALARM0 + ALARM_FIELDS * g));
    end

    // Calendar domain. Nothing here depends on a supply level, so it never stops while clocked.
    always_comb begin
        tick = 1'b0;
        wr_apply = 1'b0;
        n = r;
        n.xtal_s1 = xtal_in;
        n.xtal_s2 = r.xtal_s1;
        n.xtal_s3 = r.xtal_s2;
        n.xclk_out = r.xtal_s2;
        n.ce_s1 = chip_select;
        n.ce_s2 = r.ce_s1;
        n.wt_s1 = xfer.toggle;
        n.wt_s2 = r.wt_s1;
        n.wt_s3 = r.wt_s2;
        if (r.xtal_s2 && !r.xtal_s3) begin
            if (r.prescale == PRESCALE_W'(TICKS_PER_SEC - 1)) begin
                n.prescale = '0;
                tick = 1'b1;
            end else begin
                n.prescale = r.prescale + 1'b1;
            end
        end
        n.tick_d = tick;
        if (tick) begin
            n.regs = advance(r.regs);
        end
        // The write word is stable for two clocks before its toggle is seen here.
        wr_apply = r.wt_s2 ^ r.wt_s3;
        if (wr_apply && xfer.msg.addr < 7'(REG_COUNT)) begin
            if (xfer.msg.addr == REG_STATUS) begin
                n.regs[REG_STATUS] = r.regs[REG_STATUS] & xfer.msg.data;
            end else begin
                n.regs[xfer.msg.addr] = xfer.msg.data;
            end
            if (xfer.msg.addr == REG_SEC) begin
                n.prescale = '0;
            end
        end
        // Alarm flags are set after the write, so a set in the clearing cycle is kept.
        for (int i = 0; i < ALARM_COUNT; i++) begin
            if (r.tick_d && alarm_hit[i]) begin
                n.regs[REG_STATUS][STAT_ALARM0_BIT + i] = 1'b1;
            end
        end
        if (r.pulse_cnt != '0) begin
            n.pulse_cnt = r.pulse_cnt - 1'b1;
        end
        if (r.tick_d && alarm_hit[1] && r.regs[REG_CONTROL][CTRL_ALARM1_EN_BIT]) begin
            n.pulse_cnt = PULSE_W'(ALARM1_PULSE_LEN);
        end
        n.pulse = n.pulse_cnt != '0;
        if (!r.ce_s2) begin
            n.snap = r.regs;
        end
        n.spo_oe = r.regs[REG_CONTROL][CTRL_SECOND_PULSE_EN_BIT]
                   && (r.prescale < PRESCALE_W'(TICKS_PER_SEC / 2));
        n.irq0_oe = n.regs[REG_STATUS][STAT_ALARM0_BIT] && n.regs[REG_CONTROL][CTRL_ALARM0_EN_BIT];
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            r <= '{regs: REGS_RESET, snap: REGS_RESET, default: '0};
        end else begin
            r <= n;
        end
    end

    assign crystal_clock_out = r.xclk_out;
    assign second_pulse_out = 1'b0;
    assign second_pulse_oe = r.spo_oe;
    assign alarm0_irq_n = 1'b0;
    assign alarm0_irq_oe = r.irq0_oe;
    assign alarm1_irq_pulse = r.pulse;

    // Serial domain. Chip select low resets the link and transmit state at once, whatever the serial clock does.
    assign link_rstn = resetn & chip_select;
    assign lsb_first = !xfer.strap_s2;
    assign rx_byte = lsb_first ? {serial_data_in, link.rx[7:1]} : {link.rx[6:0], serial_data_in};

    always_comb begin
        wr_fire = 1'b0;
        link_n = link;
        link_n.rx = rx_byte;
        link_n.bitcnt = link.bitcnt + 3'h1;
        if (link.bitcnt == 3'h7) begin
            unique case (link.phase)
                PH_ADDR: begin
                    link_n.addr = rx_byte[6:0];
                    link_n.phase = rx_byte[ADDR_WRITE_BIT] ? PH_WRITE : PH_READ;
                end
                PH_WRITE: begin
                    wr_fire = 1'b1;
                    link_n.addr = link.addr + 7'h01;
                end
                PH_READ: begin
                    link_n.addr = link.addr + 7'h01;
                end
                default: begin
                    link_n.phase = PH_ADDR;
                end
            endcase
        end
    end

    always_ff @(negedge serial_clock or negedge link_rstn) begin
        if (!link_rstn) begin
            link <= '{phase: PH_ADDR, default: '0};
        end else begin
            link <= link_n;
        end
    end

    // The toggle and its word must survive chip select, or the calendar side would see a false write.
    always_comb begin
        xfer_n = xfer;
        xfer_n.strap_s1 = interface_select_strap;
        xfer_n.strap_s2 = xfer.strap_s1;
        if (wr_fire) begin
            xfer_n.msg = '{addr: link.addr, data: rx_byte};
            xfer_n.toggle = !xfer.toggle;
        end
    end

    always_ff @(negedge serial_clock or negedge resetn) begin
        if (!resetn) begin
            xfer <= '0;
        end else begin
            xfer <= xfer_n;
        end
    end

    always_ff @(negedge serial_clock) begin
        if (wr_fire && link.addr >= RAM_BASE) begin
            ram[link.addr - RAM_BASE] <= rx_byte;
        end
    end

    // The snapshot is frozen while chip select is high, so it is read here without a synchroniser.
    always_comb begin
        rd_byte = 8'h00;
        if (link.addr >= RAM_BASE) begin
            rd_byte = ram[link.addr - RAM_BASE];
        end else if (link.addr < 7'(REG_COUNT)) begin
            rd_byte = r.snap[link.addr];
        end
    end

    always_comb begin
        tx_n = tx;
        if (link.phase == PH_READ && link.bitcnt == 3'h0) begin
            tx_n.shift = rd_byte;
            tx_n.active = 1'b1;
        end else begin
            tx_n.shift = lsb_first ? {1'b0, tx.shift[7:1]} : {tx.shift[6:0], 1'b0};
        end
    end

    always_ff @(posedge serial_clock or negedge link_rstn) begin
        if (!link_rstn) begin
            tx <= '0;
        end else begin
            tx <= tx_n;
        end
    end

    assign serial_data_out = lsb_first ? tx.shift[0] : tx.shift[7];
    assign serial_data_oe = tx.active && link.phase == PH_READ;

    logic [PULSE_W-1:0] high_len;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            high_len <= '0;
        end else begin
            high_len <= alarm1_irq_pulse ? high_len + 1'b1 : '0;
        end
    end

    a_spo_disabled_idle: assert property (@(posedge clk) disable iff (!resetn)
        !r.regs[REG_CONTROL][CTRL_SECOND_PULSE_EN_BIT] |=> !second_pulse_oe)
        else $error("second pulse driven while disabled");
    a_sec_tick_advance: assert property (@(posedge clk) disable iff (!resetn)
        tick && !wr_apply |=> r.regs[REG_SEC] != $past(r.regs[REG_SEC]))
        else $error("seconds did not advance on tick");
    a_date_month_end: assert property (@(posedge clk) disable iff (!resetn)
        $past(tick) && !$past(wr_apply) && r.regs[REG_DATE] != $past(r.regs[REG_DATE])
        |-> r.regs[REG_DATE] == BCD_ONE
            || r.regs[REG_DATE] <= last_day($past(r.regs[REG_MONTH]), $past(r.regs[REG_YEAR])))
        else $error("date passed month end");
    a_hour_pm_flip: assert property (@(posedge clk) disable iff (!resetn)
        tick && !wr_apply && r.regs[REG_HOUR][HOUR_MODE_12_BIT] && r.regs[REG_HOUR][4:0] == HOUR12_ELEVEN
        && r.regs[REG_MIN] == SEC_MAX && r.regs[REG_SEC] == SEC_MAX
        |=> r.regs[REG_HOUR][HOUR_PM_BIT] != $past(r.regs[REG_HOUR][HOUR_PM_BIT]))
        else $error("AM/PM did not change at twelve");
    a_alarm_flag_set: assert property (@(posedge clk) disable iff (!resetn)
        r.tick_d && alarm_hit[0] |=> r.regs[REG_STATUS][STAT_ALARM0_BIT] ##1 alarm0_irq_oe
            == r.regs[REG_CONTROL][CTRL_ALARM0_EN_BIT] || $past(wr_apply))
        else $error("alarm 0 flag or interrupt missing");
    a_irq0_level_hold: assert property (@(posedge clk) disable iff (!resetn)
        alarm0_irq_oe == (r.regs[REG_STATUS][STAT_ALARM0_BIT] && r.regs[REG_CONTROL][CTRL_ALARM0_EN_BIT]))
        else $error("alarm 0 interrupt level wrong");
    a_pulse_width: assert property (@(posedge clk) disable iff (!resetn)
        $fell(alarm1_irq_pulse) |-> high_len == PULSE_W'(ALARM1_PULSE_LEN))
        else $error("alarm 1 pulse length wrong");
    a_sdo_read_only: assert property (@(posedge serial_clock) disable iff (!link_rstn)
        $rose(serial_data_oe) |-> link.phase == PH_READ && link.bitcnt == 3'h1)
        else $error("data line driven outside read bits");
    a_write_hands_over: assert property (@(negedge serial_clock) disable iff (!link_rstn)
        link.phase == PH_WRITE && link.bitcnt == 3'h7 |=> xfer.toggle != $past(xfer.toggle))
        else $error("completed write byte not handed over");

    c_alarm1_pulse: cover property (@(posedge clk) disable iff (!resetn) $rose(alarm1_irq_pulse));
    c_alarm0_irq: cover property (@(posedge clk) disable iff (!resetn) $rose(alarm0_irq_oe));
    c_serial_read: cover property (@(posedge serial_clock) disable iff (!link_rstn) $rose(serial_data_oe));
    c_serial_write: cover property (@(posedge clk) disable iff (!resetn) wr_apply);
endmodule // serial_alarm_rtc

// File: testbench/serial_host.sv
// Purpose: Host model that masters the serial port of the clock.
// Assumes: Serial clock of 64 ns, idle low, standing still between frames.
// Notes: Data changes after the rising edge so the device takes it at the falling edge.
`timescale 1ns/100ps
module serial_host (
    input wire logic strap,
    input wire logic miso,
    output logic chip_select,
    output logic serial_clock,
    output logic host_d,
    output logic host_oe
);
    logic [7:0] wbuf [0:8];
    logic [7:0] rbuf [0:8];

    initial begin
        chip_select = 1'b0;
        serial_clock = 1'b0;
        host_d = 1'b0;
        host_oe = 1'b0;
    end

    task automatic send(input logic [7:0] b, input logic drive, input int nb, output logic [7:0] got);
        got = 8'h00;
        for (int i = 0; i < nb; i++) begin
            serial_clock = 1'b1;
            host_oe = drive;
            host_d = strap ? b[7 - i] : b[i];
            #31;
            if (strap) got[7 - i] = miso;
            else got[i] = miso;
            #1 serial_clock = 1'b0;
            #32;
        end
    endtask

    // A nonzero cut shortens the last byte so that the frame is torn mid-byte.
    task automatic frame(input logic [7:0] a, input int n, input int cut);
        logic [7:0] dummy;
        chip_select = 1'b1;
        #43.3;
        send(a, 1'b1, 8, dummy);
        for (int k = 0; k < n; k++) begin
            send(wbuf[k], a[7], (k == n - 1) ? 8 - cut : 8, rbuf[k]);
        end
        host_oe = 1'b0;
        #32 chip_select = 1'b0;
        #64;
    endtask
endmodule // serial_host

// File: testbench/tb.sv
// Purpose: Self-checking bench of the serial alarm clock through its serial port.
// Assumes: Crystal runs fast and a second is eight rising crystal edges, so a second lasts 4096 ns.
// Notes: An undriven data line shows a toggling pattern rather than a held level.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, exp, got); end end
module tb;
    import rtc_pkg::*;
    localparam int PULSE_LEN = 20;
    localparam logic [55:0] WIN [4] = '{56'h59592307280201, 56'h59592307280204, 56'h59592307300405,
        56'h59597107311299};
    localparam logic [55:0] WEXP [4] = '{56'h00000001010301, 56'h00000001290204, 56'h00000001010505,
        56'h00005201010100};
    logic clk, resetn, xtal_in, strap, miso, host_d, host_oe;
    logic junk = 1'b0;
    logic crystal_clock_out, second_pulse_out, second_pulse_oe, alarm0_irq_n, alarm0_irq_oe, alarm1_irq_pulse;
    logic chip_select, serial_clock, serial_data_in, serial_data_out, serial_data_oe;
    int error_cnt = 0;
    int total_checks = 0;
    int sp_rise = 0;
    int xo_edge = 0;
    int width = 0;

    assign serial_data_in = (!strap && serial_data_oe) ? serial_data_out : (host_oe ? host_d : junk);
    assign miso = serial_data_oe ? serial_data_out : junk;

    serial_alarm_rtc #(.ALARM1_PULSE_LEN(PULSE_LEN), .TICKS_PER_SEC(8)) dut (.clk(clk), .resetn(resetn),
        .xtal_in(xtal_in), .crystal_clock_out(crystal_clock_out), .second_pulse_out(second_pulse_out),
        .second_pulse_oe(second_pulse_oe), .alarm0_irq_n(alarm0_irq_n), .alarm0_irq_oe(alarm0_irq_oe),
        .alarm1_irq_pulse(alarm1_irq_pulse), .interface_select_strap(strap), .chip_select(chip_select),
        .serial_clock(serial_clock), .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .serial_data_oe(serial_data_oe));
    serial_host host (.strap(strap), .miso(miso), .chip_select(chip_select), .serial_clock(serial_clock),
        .host_d(host_d), .host_oe(host_oe));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        xtal_in = 1'b0;
        forever #256 xtal_in = ~xtal_in;
    end
    always @(negedge clk) junk <= ~junk;
    always @(posedge second_pulse_oe) sp_rise++;
    always @(crystal_clock_out) xo_edge++;
    // Counted on the falling edge, where the registered pulse has settled.
    always @(negedge clk) if (alarm1_irq_pulse === 1'b1) width++;
    always @(negedge clk) if (resetn) `CHK("open drain level", 2'b00, {second_pulse_out, alarm0_irq_n})

    task automatic end_of_test();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // The strap settles over two serial clock edges; address zero reads alike in both bit orders.
    task automatic set_mode(input logic m);
        @(negedge clk);
        strap = m;
        host.frame(8'h00, 1, 0);
    endtask

    initial begin
        // The whole run takes about 87 us.
        #400000;
        error_cnt++;
        end_of_test();
    end

    initial begin
        resetn = 1'b0;
        strap = 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        resetn = 1'b1;
        set_mode(1'b1);
        for (int r = 0; r < 4; r++) begin
            if (r == 2) set_mode(1'b0);
            for (int k = 0; k < 7; k++) host.wbuf[k] = WIN[r][55 - 8 * k -: 8];
            host.frame(8'h80, 7, 0);
            #2000;
            host.frame(8'h00, 7, 0);
            for (int k = 0; k < 7; k++) `CHK("calendar", WEXP[r][55 - 8 * k -: 8], host.rbuf[k])
        end
        host.wbuf[0] = 8'hA5;
        host.wbuf[1] = 8'h3C;
        host.frame(8'hFE, 2, 0);
        host.wbuf[0] = 8'h00;
        host.frame(8'hFE, 1, 4);
        host.wbuf[0] = 8'hFF;
        host.frame(8'h92, 1, 0);
        host.frame(8'h12, 1, 0);
        `CHK("reserved", 8'h00, host.rbuf[0])
        host.frame(8'h7E, 2, 0);
        `CHK("ram low", 8'hA5, host.rbuf[0])
        `CHK("ram high", 8'h3C, host.rbuf[1])
        `CHK("data released", 1'b0, serial_data_oe)
        for (int k = 0; k < 9; k++) host.wbuf[k] = (k == 4) ? 8'h02 : 8'h80;
        host.wbuf[8] = 8'h07;
        host.frame(8'h87, 9, 0);
        host.wbuf[0] = 8'h00;
        width = 0;
        host.frame(8'h80, 1, 0);
        for (int t = 0; t < 3000 && alarm1_irq_pulse !== 1'b1; t++) @(negedge clk);
        repeat (40) @(negedge clk);
        `CHK("alarm1 pulse width", PULSE_LEN, width)
        `CHK("alarm0 irq", 1'b1, alarm0_irq_oe)
        host.frame(8'h10, 1, 0);
        `CHK("status", 8'h03, host.rbuf[0])
        // Writing zero clears both flags well before the next second sets the alarm 0 flag again.
        host.wbuf[0] = 8'h00;
        host.frame(8'h90, 1, 0);
        host.frame(8'h10, 1, 0);
        `CHK("status cleared", 8'h00, host.rbuf[0])
        `CHK("alarm0 irq cleared", 1'b0, alarm0_irq_oe)
        @(negedge clk);
        sp_rise = 0;
        xo_edge = 0;
        #8192;
        `CHK("second pulse on", 2, sp_rise)
        `CHK("crystal out", 32, xo_edge)
        host.wbuf[0] = 8'h00;
        host.frame(8'h8F, 1, 0);
        `CHK("alarm0 irq off", 1'b0, alarm0_irq_oe)
        @(negedge clk);
        sp_rise = 0;
        xo_edge = 0;
        #8192;
        `CHK("second pulse off", 0, sp_rise)
        `CHK("second pulse idle", 1'b0, second_pulse_oe)
        `CHK("crystal out free", 32, xo_edge)
        end_of_test();
    end
endmodule // tb
